// ### hw/hrsc_pkg.sv
package hrsc_pkg;
    localparam int PORT_COUNT = 7;
    localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2C;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        CFG_RESERVED = 2'b00,
        CFG_SMBUS = 2'b01,
        CFG_INTERNAL = 2'b10,
        CFG_EEPROM = 2'b11
    } hrsc_cfg_e;

    typedef struct packed {
        logic ledSupport;
        logic multiTranslator;
        logic gangedPower;
        logic powerPolarity;
        hrsc_cfg_e cfgSource;
    } hrsc_straps_s;

    // Power drive level for a wanted enable under a given polarity
    function automatic logic [6:0] hrscPowerLevel(input logic [6:0] enable, input logic polarity);
        return polarity ? enable : ~enable;
    endfunction

    // Pin level for a wanted LED state under active-high or active-low
    function automatic logic hrscLedLevel(input logic on, input logic activeLow);
        return activeLow ? ~on : on;
    endfunction
endpackage

// ### hw/hrsc_strap_config.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Internal default: port4 amber sampled for LED support
// - Low disables LED; high makes it active low
// - Port2 amber strap: single or multi translator
// - Port3 amber driven active low in every mode; undriven in reset
// - In reset, polarity strap sets power outputs off
// - Polarity latched at reset release, then kept
// - Polarity one active high, zero active low
// - Select pins latched; 00 reserved, 11 EEPROM
// - Code 01 selects SMBus slave at 0101100
// - Code 10 selects internal default straps
// - Power output at active level powers port
module hrsc_strap_config
    import hrsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire logic ledSupportStrap,
    input wire logic multiTranslatorStrap,
    input wire logic gangedPowerStrap,
    input wire logic powerPolarityStrap,
    input wire logic configSelectLo,
    input wire logic configSelectHi,
    input wire logic [6:0] overcurrentInN,
    input wire logic [6:0] portPowerReq,
    input wire logic [3:0] amberLedReq,
    output logic [6:0] portPowerOut,
    output logic [3:0] amberLedOut,
    output logic [3:0] amberLedOeN,
    output logic [6:0] overcurrentSeen,
    output hrsc_straps_s strapsOut,
    output logic smbusSlaveEn,
    output logic [6:0] smbusSlaveAddr,
    output logic eepromLoadEn,
    output logic internalCfgEn,
    output logic singleTranslator,
    output logic configValid
);
    // Three-stage synchronisers; stage 1 only feeds stage 2
    logic [SYNC_STAGES-1:0] rstSync_q, polSync_q;
    logic [SYNC_STAGES-1:0] ledSync_q, mttSync_q, gangSync_q, selLoSync_q, selHiSync_q;
    logic [6:0] ocS1_q, ocS2_q, ocS3_q;
    logic rstActive_q, inReset;
    logic releaseEdge;
    hrsc_straps_s straps_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rstSync_q <= '0;
            polSync_q <= '0;
            ledSync_q <= '0;
            mttSync_q <= '0;
            gangSync_q <= '0;
            selLoSync_q <= '0;
            selHiSync_q <= '0;
        end else begin
            rstSync_q <= {rstSync_q[1:0], resetPinN};
            polSync_q <= {polSync_q[1:0], powerPolarityStrap};
            ledSync_q <= {ledSync_q[1:0], ledSupportStrap};
            mttSync_q <= {mttSync_q[1:0], multiTranslatorStrap};
            gangSync_q <= {gangSync_q[1:0], gangedPowerStrap};
            selLoSync_q <= {selLoSync_q[1:0], configSelectLo};
            selHiSync_q <= {selHiSync_q[1:0], configSelectHi};
        end
    end

    // Reset pin level counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rstActive_q <= 1'b1;
        end else if (rstSync_q[1] == rstSync_q[2]) begin
            rstActive_q <= ~rstSync_q[2];
        end
    end

    assign inReset = rstActive_q;
    assign releaseEdge = rstActive_q && rstSync_q[1] && rstSync_q[2];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            straps_q <= '{ledSupport: 1'b0, multiTranslator: 1'b0, gangedPower: 1'b0,
                          powerPolarity: 1'b0, cfgSource: CFG_RESERVED};
        end else if (releaseEdge) begin
            straps_q.ledSupport <= ledSync_q[2];
            straps_q.multiTranslator <= mttSync_q[2];
            straps_q.gangedPower <= gangSync_q[2];
            straps_q.powerPolarity <= polSync_q[2];
            straps_q.cfgSource <= hrsc_cfg_e'({selHiSync_q[2], selLoSync_q[2]});
        end
    end

    // Overcurrent sampled; pins idle high when undriven
    // Set and clear need two agreeing stages, so a one-cycle glitch is ignored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ocS1_q <= 7'h7F;
            ocS2_q <= 7'h7F;
            ocS3_q <= 7'h7F;
            overcurrentSeen <= 7'h00;
        end else begin
            ocS1_q <= overcurrentInN;
            ocS2_q <= ocS1_q;
            ocS3_q <= ocS2_q;
            overcurrentSeen <= (~ocS2_q & ~ocS3_q) | (overcurrentSeen & ~(ocS2_q & ocS3_q));
        end
    end

    // Port power drive; in reset, live strap level forces all off
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            portPowerOut <= 7'h00;
        end else if (inReset) begin
            portPowerOut <= hrscPowerLevel(7'h00, polSync_q[2]);
        end else begin
            portPowerOut <= hrscPowerLevel(portPowerReq & ~overcurrentSeen, straps_q.powerPolarity);
        end
    end

    // Amber LEDs; index 0 is port 1
    logic internalMode;
    assign internalMode = (straps_q.cfgSource == CFG_INTERNAL);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            amberLedOut <= 4'hF;
            amberLedOeN <= 4'hF;
        end else if (inReset) begin
            // Strap pins stay undriven so straps can be read
            amberLedOut <= 4'hF;
            amberLedOeN <= 4'hF;
        end else begin
            amberLedOut[0] <= hrscLedLevel(amberLedReq[0], !internalMode || straps_q.gangedPower);
            amberLedOut[1] <= hrscLedLevel(amberLedReq[1], !internalMode || straps_q.multiTranslator);
            amberLedOut[2] <= hrscLedLevel(amberLedReq[2], 1'b1);
            amberLedOut[3] <= hrscLedLevel(amberLedReq[3] && (!internalMode || straps_q.ledSupport), 1'b1);
            amberLedOeN <= 4'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            smbusSlaveEn <= 1'b0;
            smbusSlaveAddr <= 7'h00;
            eepromLoadEn <= 1'b0;
            internalCfgEn <= 1'b0;
            singleTranslator <= 1'b0;
            configValid <= 1'b0;
            strapsOut <= '0;
        end else begin
            smbusSlaveEn <= !inReset && straps_q.cfgSource == CFG_SMBUS;
            smbusSlaveAddr <= SMBUS_SLAVE_ADDR;
            eepromLoadEn <= !inReset && straps_q.cfgSource == CFG_EEPROM;
            internalCfgEn <= !inReset && internalMode;
            singleTranslator <= internalMode && !straps_q.multiTranslator;
            configValid <= !inReset && straps_q.cfgSource != CFG_RESERVED;
            strapsOut <= straps_q;
        end
    end

    chk_power_reset_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        inReset |=> portPowerOut == {7{~$past(polSync_q[2])}})
        else $error("Port power on during reset");
    chk_polarity_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        releaseEdge |=> straps_q.powerPolarity == $past(polSync_q[2]))
        else $error("Polarity not latched");
    chk_power_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset && $stable(inReset) |=> portPowerOut ==
            $past(hrscPowerLevel(portPowerReq & ~overcurrentSeen, straps_q.powerPolarity)))
        else $error("Power level wrong");
    chk_port3_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset ##1 !inReset |-> amberLedOut[2] == !$past(amberLedReq[2]))
        else $error("Port3 LED not active low");
    chk_led_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset && internalMode && !straps_q.ledSupport ##1 !inReset |-> amberLedOut[3])
        else $error("Disabled LED lit");
    chk_straps_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset |=> $stable(straps_q))
        else $error("Straps changed after release");
    chk_smbus_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
        smbusSlaveEn |-> smbusSlaveAddr == 7'h2C && straps_q.cfgSource == CFG_SMBUS)
        else $error("SMBus mode wrong");
    chk_cfg_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        releaseEdge |=> straps_q.cfgSource == hrsc_cfg_e'($past({selHiSync_q[2], selLoSync_q[2]})))
        else $error("Select not captured");
    chk_internal_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
        internalCfgEn |-> straps_q.cfgSource == CFG_INTERNAL && !smbusSlaveEn && !eepromLoadEn)
        else $error("Internal mode wrong");
    chk_port1_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset && internalMode && !straps_q.gangedPower ##1 !inReset |-> amberLedOut[0] == $past(amberLedReq[0]))
        else $error("Port1 LED not active high");
    chk_port2_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset && internalMode && !straps_q.multiTranslator ##1 !inReset |-> amberLedOut[1] == $past(amberLedReq[1]))
        else $error("Port2 LED not active high");
    chk_oe_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
        inReset |=> amberLedOeN == 4'hF)
        else $error("Strap pin driven during reset");
    chk_oe_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inReset |=> amberLedOeN == 4'h0)
        else $error("LED pin not driven after release");

    // Per-port power and a disabled LED only arise under internal mode
    cov_release: cover property (@(posedge clk_sys) releaseEdge);
    cov_internal: cover property (@(posedge clk_sys) internalCfgEn && singleTranslator);
    cov_eeprom: cover property (@(posedge clk_sys) eepromLoadEn);
    cov_per_port: cover property (@(posedge clk_sys) internalCfgEn && !strapsOut.gangedPower);
    cov_led_off: cover property (@(posedge clk_sys) internalCfgEn && !strapsOut.ledSupport);
endmodule

// ### sim/hrsc_board_model.sv
`timescale 1ns/10ps
module hrsc_board_model (
    input wire logic [5:0] strapSet,
    input wire logic [6:0] ocFault,
    output logic ledSupportStrap,
    output logic multiTranslatorStrap,
    output logic gangedPowerStrap,
    output logic powerPolarityStrap,
    output logic configSelectHi,
    output logic configSelectLo,
    output logic [6:0] overcurrentInN
);
    // Strap resistors: levels stand as fitted
    assign {ledSupportStrap, multiTranslatorStrap, gangedPowerStrap, powerPolarityStrap, configSelectHi,
        configSelectLo} = strapSet;
    assign overcurrentInN = ~ocFault;
endmodule

// ### sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    import hrsc_pkg::*;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic resetPinN = 0;
    logic [5:0] strapSet = 6'h00;
    logic [5:0] s;
    logic [6:0] ocFault = 7'h00;
    logic [6:0] portPowerReq = 7'h00;
    logic [3:0] amberLedReq = 4'h0;
    logic [7:0] rnd = 8'h2C;
    logic ls, ms, gs, ps, ch, cl, smb, eep, intEn, cv, single_translator;
    logic [6:0] ocN, pwr, ocSeen, addr;
    logic [3:0] led, ledOeN;
    hrsc_straps_s st;
    // Strap sets as the model latched them, newest last
    logic [5:0] latched[$];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    hrsc_board_model board (.strapSet(strapSet), .ocFault(ocFault), .ledSupportStrap(ls),
        .multiTranslatorStrap(ms), .gangedPowerStrap(gs), .powerPolarityStrap(ps), .configSelectHi(ch),
        .configSelectLo(cl), .overcurrentInN(ocN));
    hrsc_strap_config dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .resetPinN(resetPinN), .ledSupportStrap(ls),
        .multiTranslatorStrap(ms), .gangedPowerStrap(gs), .powerPolarityStrap(ps), .configSelectLo(cl),
        .configSelectHi(ch), .overcurrentInN(ocN), .portPowerReq(portPowerReq), .amberLedReq(amberLedReq),
        .portPowerOut(pwr), .amberLedOut(led), .amberLedOeN(ledOeN), .overcurrentSeen(ocSeen), .strapsOut(st),
        .smbusSlaveEn(smb), .smbusSlaveAddr(addr), .eepromLoadEn(eep), .internalCfgEn(intEn),
        .singleTranslator(single_translator), .configValid(cv));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Expectations come from the sampled straps, not from the live pins
    task automatic check_all(input logic [5:0] v);
        logic [6:0] on;
        logic intl;
        logic [6:0] pwrExp;
        on = portPowerReq & ~ocFault;
        intl = (v[1:0] == 2'b10);
        pwrExp = v[2] ? on : ~on;
        cmp("power", pwr, pwrExp);
        cmp("ocSeen", ocSeen, ocFault);
        cmp("straps", st, v);
        cmp("smbus", smb, v[1:0] == 2'b01);
        cmp("eeprom", eep, v[1:0] == 2'b11);
        cmp("internal", intEn, intl);
        cmp("valid", cv, v[1:0] != 2'b00);
        cmp("single", single_translator, intl && !v[4]);
        cmp("addr", addr, 7'h2C);
        cmp("ledOe", ledOeN, 4'h0);
        cmp("am3", led[2], !amberLedReq[2]);
        cmp("am1", led[0], (intl && !v[3]) ? amberLedReq[0] : !amberLedReq[0]);
        cmp("am2", led[1], (intl && !v[4]) ? amberLedReq[1] : !amberLedReq[1]);
        if (!intl || v[5]) cmp("am4", led[3], !amberLedReq[3]);
        else cmp("am4Off", led[3], 1'b1);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 2000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 0;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            // Flipping the ganged strap in the upper half gives internal mode both power modes
            s = {rnd[3:0] ^ {2'b00, i[2], 1'b0}, i[1:0]};
            strapSet <= s;
            resetPinN <= 0;
            ocFault <= 7'h00;
            rnd = lfsr(rnd);
            portPowerReq <= rnd[6:0];
            amberLedReq <= rnd[3:0];
            repeat (8) @(posedge clk_sys);
            #1;
            cmp("pwrInRst", pwr, s[2] ? 7'h00 : 7'h7F);
            cmp("oeInRst", ledOeN, 4'hF);
            @(posedge clk_sys);
            resetPinN <= 1;
            latched.push_back(s);
            repeat (8) @(posedge clk_sys);
            #1;
            check_all(latched[$]);
            @(posedge clk_sys);
            // Late strap moves must not reach the latched set
            strapSet <= ~s;
            ocFault <= rnd[7:1];
            repeat (10) @(posedge clk_sys);
            #1;
            check_all(latched[$]);
            @(posedge clk_sys);
        end
        give_verdict();
    end
endmodule
